/* File: rtl/gch_pkg.sv */
package gch_pkg;
    // automation output bit image: bits 256..327, held here as 72 bits
    localparam int OUT_BASE      = 256;
    localparam int OUT_WIDTH     = 72;
    localparam int CMD_LSB       = 256 - OUT_BASE;
    localparam int CMD_W         = 12;
    localparam int TGT_LSB       = 268 - OUT_BASE;
    localparam int TGT_W         = 8;
    localparam int VAL_LSB       = 288 - OUT_BASE;
    localparam int VAL_W         = 32;
    localparam int RD_BIT        = 320 - OUT_BASE;
    localparam int WR_BIT        = 321 - OUT_BASE;
    // automation input bit image: bits 128..163, held here as 36 bits
    localparam int IN_BASE       = 128;
    localparam int IN_WIDTH      = 36;
    localparam int RVAL_LSB      = 128 - IN_BASE;
    localparam int ST_ACTIVE     = 160 - IN_BASE;
    localparam int ST_SUCCESS    = 161 - IN_BASE;
    localparam int ST_FAILURE    = 162 - IN_BASE;
    localparam int ST_COERCED    = 163 - IN_BASE;
    localparam logic [8:0] STYLES_A = 9'h010;
    localparam logic [8:0] STYLES_B = 9'h100;
    localparam int SETTING_DEPTH = 16;
    localparam int SETTING_AW    = 4;
    // controller register map (AXI4-Lite byte offsets)
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_CMD     = 8'h04;
    localparam logic [7:0] A_WVAL    = 8'h08;
    localparam logic [7:0] A_RVAL    = 8'h0C;
    localparam logic [7:0] A_IRQ_ST  = 8'h10;
    localparam logic [7:0] A_IRQ_MSK = 8'h14;
    localparam int CTRL_GO       = 0;
    localparam int CTRL_WRITE    = 1;
    localparam int CTRL_BOTH     = 2;
    localparam int IRQ_DONE      = 0;
    localparam int IRQ_FAIL      = 1;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        GCH_IDLE = 2'b00,
        GCH_BUSY = 2'b01,
        GCH_DONE = 2'b11
    } gch_state_t;
endpackage : gch_pkg

/* File: rtl/gch_link_if.sv */
`timescale 1ns/1ps
interface gch_link_if;
    import gch_pkg::*;
    logic [OUT_WIDTH-1:0] out_bits;
    logic [IN_WIDTH-1:0]  in_bits;
    modport gateway (input out_bits, output in_bits);
    modport controller (output out_bits, input in_bits);
endinterface : gch_link_if

/* File: rtl/gch_gateway.sv */
`timescale 1ns/1ps
module gch_gateway #(
    parameter int          DEPTH   = gch_pkg::SETTING_DEPTH,
    parameter logic [31:0] VAL_MAX = 32'h0000_FFFF,
    parameter logic [7:0]  TGT_ID  = 8'hB0
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [8:0]    styles,
    gch_link_if.gateway        link
);
    import gch_pkg::*;

    // link pins come from another party: two-stage sync first
    logic [OUT_WIDTH-1:0] sync1_reg;
    logic [OUT_WIDTH-1:0] sync2_reg;
    gch_state_t           state_reg;
    gch_state_t           state_next;
    logic [31:0]          rval_reg;
    logic [3:0]           status_reg;
    logic [31:0]          mem_reg [DEPTH];

    // only assigned fields are decoded; the rest are never read
    wire logic [CMD_W-1:0] cmd    = sync2_reg[CMD_LSB +: CMD_W];
    wire logic [TGT_W-1:0] tgt    = sync2_reg[TGT_LSB +: TGT_W];
    wire logic [VAL_W-1:0] wval   = sync2_reg[VAL_LSB +: VAL_W];
    wire logic             rd_req = sync2_reg[RD_BIT];
    wire logic             wr_req = sync2_reg[WR_BIT];
    wire logic             any_req = rd_req | wr_req;
    wire logic             avail  = (styles == STYLES_A) || (styles == STYLES_B);
    wire logic [SETTING_AW-1:0] idx = cmd[SETTING_AW-1:0];
    wire logic             hit    = (tgt == TGT_ID) && (32'(cmd) < 32'(DEPTH));
    wire logic             clash  = rd_req & wr_req;
    wire logic             fail   = clash | ~hit | ~avail;
    wire logic             over   = wval > VAL_MAX;
    // out-of-range values are clamped, not refused
    wire logic [31:0]      stored = over ? VAL_MAX : wval;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            GCH_IDLE: if (any_req) state_next = GCH_BUSY;
            GCH_BUSY: state_next = any_req ? GCH_DONE : GCH_IDLE;
            GCH_DONE: if (!any_req) state_next = GCH_IDLE;
            default:  state_next = GCH_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (ce) begin
            sync1_reg <= link.out_bits;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg  <= GCH_IDLE;
            status_reg <= 4'h0;
            rval_reg   <= 32'h0000_0000;
        end else if (ce) begin
            state_reg <= state_next;
            case (state_reg)
                GCH_IDLE: if (any_req) status_reg <= 4'h1;
                GCH_BUSY: begin
                    if (!any_req) begin
                        status_reg <= 4'h0;
                    end else if (fail) begin
                        status_reg <= 4'h5;
                    end else if (wr_req) begin
                        status_reg <= over ? 4'h9 : 4'h3;
                        rval_reg   <= stored;
                    end else begin
                        status_reg <= 4'h3;
                        rval_reg   <= mem_reg[idx];
                    end
                end
                GCH_DONE: if (!any_req) status_reg <= 4'h0;
                default:  status_reg <= 4'h0;
            endcase
        end
    end

    // settings store; not reset, stands in for the plate's own values
    always_ff @(posedge clk_sys) begin
        if (ce && state_reg == GCH_BUSY && wr_req && !fail) begin
            mem_reg[idx] <= stored;
        end
    end

    assign link.in_bits[RVAL_LSB +: 32] = rval_reg;
    assign link.in_bits[ST_ACTIVE]  = status_reg[0];
    assign link.in_bits[ST_SUCCESS] = status_reg[1];
    assign link.in_bits[ST_FAILURE] = status_reg[2];
    assign link.in_bits[ST_COERCED] = status_reg[3];
endmodule : gch_gateway

/* File: rtl/gch_controller.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module gch_controller (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    gch_link_if.controller   link
);
    import gch_pkg::*;

    logic [OUT_WIDTH-1:0] out_reg;
    logic [IN_WIDTH-1:0]  in1_reg;
    logic [IN_WIDTH-1:0]  in2_reg;
    logic [19:0]          cmd_reg;
    logic [31:0]          wval_reg;
    logic [1:0]           irq_st_reg;
    logic [1:0]           irq_msk_reg;
    logic                 phase_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           rresp_reg;
    logic                 bvalid_reg;
    logic                 rvalid_reg;
    logic [1:0]           bresp_reg;

    wire logic active  = in2_reg[ST_ACTIVE];
    wire logic done    = in2_reg[ST_SUCCESS] | in2_reg[ST_FAILURE] | in2_reg[ST_COERCED];
    wire logic busy    = out_reg[RD_BIT] | out_reg[WR_BIT];
    // finish one cycle: drop request once completion seen after active
    wire logic finish  = busy & phase_reg & done;
    // no handshake while frozen, or a beat would be lost
    wire logic wr_go   = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    wire logic rd_go   = ce & s_axi_arvalid & ~rvalid_reg;
    wire logic w_ctrl  = wr_go && s_axi_awaddr == A_CTRL;
    wire logic w_ok    = s_axi_awaddr == A_CTRL || s_axi_awaddr == A_CMD ||
                         s_axi_awaddr == A_WVAL || s_axi_awaddr == A_IRQ_ST ||
                         s_axi_awaddr == A_IRQ_MSK;
    wire logic [1:0] ev = {finish & in2_reg[ST_FAILURE], finish};

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = |(irq_st_reg & irq_msk_reg);
    assign link.out_bits = out_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in1_reg <= '0;
            in2_reg <= '0;
        end else if (ce) begin
            in1_reg <= link.in_bits;
            in2_reg <= in1_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_reg   <= '0;
            phase_reg <= 1'b0;
        end else if (ce) begin
            if (!busy) begin
                phase_reg <= 1'b0;
                // fields set on the same edge as the request bit; unused bits stay low
                if (w_ctrl && s_axi_wdata[CTRL_GO] && s_axi_wstrb[0]) begin
                    out_reg[CMD_LSB +: 20]    <= cmd_reg;
                    out_reg[VAL_LSB +: VAL_W] <= wval_reg;
                    out_reg[WR_BIT] <= s_axi_wdata[CTRL_WRITE] | s_axi_wdata[CTRL_BOTH];
                    out_reg[RD_BIT] <= ~s_axi_wdata[CTRL_WRITE] | s_axi_wdata[CTRL_BOTH];
                end
            end else if (active && !done) begin
                phase_reg <= 1'b1;
            end else if (finish) begin
                out_reg[RD_BIT] <= 1'b0;
                out_reg[WR_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_reg     <= 20'h00000;
            wval_reg    <= 32'h0000_0000;
            irq_msk_reg <= 2'h0;
            irq_st_reg  <= 2'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else if (ce) begin
            // set beats clear on the same cycle
            irq_st_reg <= (irq_st_reg &
                ~((wr_go && s_axi_awaddr == A_IRQ_ST) ? s_axi_wdata[1:0] : 2'h0)) | ev;
            if (s_axi_bvalid && s_axi_bready) bvalid_reg <= 1'b0;
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= w_ok ? RESP_OKAY : RESP_SLVERR;
                if (s_axi_awaddr == A_CMD)     cmd_reg     <= s_axi_wdata[19:0];
                if (s_axi_awaddr == A_WVAL)    wval_reg    <= s_axi_wdata;
                if (s_axi_awaddr == A_IRQ_MSK) irq_msk_reg <= s_axi_wdata[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready) rvalid_reg <= 1'b0;
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= RESP_OKAY;
                case (s_axi_araddr)
                    A_CTRL:    rdata_reg <= {27'h0, in2_reg[ST_COERCED:ST_ACTIVE], busy};
                    A_CMD:     rdata_reg <= {12'h000, cmd_reg};
                    A_WVAL:    rdata_reg <= wval_reg;
                    A_RVAL:    rdata_reg <= in2_reg[RVAL_LSB +: 32];
                    A_IRQ_ST:  rdata_reg <= {30'h0, irq_st_reg};
                    A_IRQ_MSK: rdata_reg <= {30'h0, irq_msk_reg};
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule : gch_controller

/* File: sim/gch_asserts.sv */
`timescale 1ns/1ps
module gch_asserts #(
    parameter logic [31:0] VAL_MAX = 32'h0000_FFFF
) (
    input wire logic                          clk_sys,
    input wire logic                          rst,
    input wire logic                          ce,
    input wire logic [gch_pkg::OUT_WIDTH-1:0] out_bits,
    input wire logic [gch_pkg::IN_WIDTH-1:0]  in_bits
);
    import gch_pkg::*;
    wire logic        rd   = out_bits[RD_BIT];
    wire logic        wr   = out_bits[WR_BIT];
    wire logic        req  = rd | wr;
    wire logic        act  = in_bits[ST_ACTIVE];
    wire logic        succ = in_bits[ST_SUCCESS];
    wire logic        fail = in_bits[ST_FAILURE];
    wire logic        coer = in_bits[ST_COERCED];
    wire logic        done = succ | fail | coer;
    wire logic [31:0] rval = in_bits[RVAL_LSB +: 32];
    wire logic [31:0] wval = out_bits[VAL_LSB +: VAL_W];
    wire logic [3:0]  stat = in_bits[ST_COERCED:ST_ACTIVE];
    wire logic [17:0] spare = {out_bits[71:66], out_bits[31:20]};

    default clocking @(posedge clk_sys); endclocking
    // a freeze stalls both ends, so open timing windows are dropped
    default disable iff (rst || !ce);

    sequence s_req_up;
        $rose(req);
    endsequence
    sequence s_active_soon;
        ##[2:4] act;
    endsequence
    property p_accept;
        s_req_up |-> s_active_soon;
    endproperty

    // coerced outlives the request by the sync delay; judge it only while held
    property p_coerce;
        coer && req |-> wr && rval == VAL_MAX && wval > VAL_MAX;
    endproperty

    AST_ACCEPT: assert property (p_accept) else $error("active late");
    AST_BOTH_FAIL: assert property ((rd && wr) [*6] |-> fail)
        else $error("no failure");
    AST_ACT_FIRST: assert property ($rose(done) |-> $past(act))
        else $error("early status");
    AST_DONE_ACT: assert property (done |-> act)
        else $error("status without active");
    AST_ONE_OUT: assert property ($onehot0({succ, fail, coer}))
        else $error("two outcomes");
    AST_HOLD: assert property (done && req |=> $stable(in_bits))
        else $error("status moved");
    AST_CLEAR: assert property ($fell(req) |-> ##[1:6] stat == 4'h0)
        else $error("no clear");
    AST_IDLE: assert property ((!req) [*8] |-> stat == 4'h0)
        else $error("idle status");
    AST_STORED: assert property (wr && !rd && succ |-> rval == wval)
        else $error("bad stored");
    AST_COERCE: assert property (p_coerce) else $error("bad coerce");
    AST_SPARE: assert property (spare == 18'h00000)
        else $error("spare bits driven");
endmodule : gch_asserts

/* File: sim/tb_gateway_command_handshake.sv */
`timescale 1ns/1ps
module tb_gateway_command_handshake;
    import gch_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        ce      = 1'b1;
    logic [8:0]  styles  = STYLES_A;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        saw_coer = 1'b0;
    int          errors = 0;
    int          cmp_count = 0;

    gch_link_if link ();
    always #12.5 clk_sys = ~clk_sys;
    // wire-level view of the coerced flag, which lasts only a few cycles
    always @(posedge clk_sys) if (link.in_bits[ST_COERCED] === 1'b1) saw_coer <= 1'b1;

    gch_gateway u_gch_gateway (.clk_sys(clk_sys), .rst(rst), .ce(ce), .styles(styles),
        .link(link));
    gch_controller u_gch_controller (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link));
    gch_asserts #(.VAL_MAX(32'h0000_FFFF)) chk_asserts (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .out_bits(link.out_bits), .in_bits(link.in_bits));

    task automatic end_sim;
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic timeout;
        chk("wait_limit", 32'h0, 32'h1);
        end_sim();
    endtask : timeout

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_sys);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // one full command: fields, go, wire check, wait for completion irq
    task automatic do_cmd(input logic [11:0] c, input logic [7:0] t, input logic [31:0] v,
                          input logic [2:0] ctl, input logic fexp, output logic [31:0] rv);
        logic [1:0]  r;
        logic [31:0] st;
        int          i;
        axi_wr(A_IRQ_ST, 32'h3, r);
        axi_wr(A_CMD, {12'h0, t, c}, r);
        axi_wr(A_WVAL, v, r);
        axi_wr(A_CTRL, {29'h0, ctl}, r);
        for (i = 0; i < 40 && link.out_bits[WR_BIT:RD_BIT] == 2'b00; i++) @(posedge clk_sys);
        if (i == 40) timeout();
        chk("cmd_field", {12'h0, t, c}, {12'h0, link.out_bits[19:0]});
        chk("req_bits", {30'h0, ctl[2] | ctl[1], ctl[2] | !ctl[1]},
            {30'h0, link.out_bits[WR_BIT], link.out_bits[RD_BIT]});
        if (ctl[1]) chk("val_field", v, link.out_bits[VAL_LSB +: 32]);
        st = 32'h0;
        for (i = 0; i < 40 && st[1:0] == 2'b00; i++) axi_rd(A_IRQ_ST, st, r);
        if (i == 40) timeout();
        chk("fail_flag", {31'h0, fexp}, {31'h0, st[IRQ_FAIL]});
        axi_rd(A_RVAL, rv, r);
    endtask : do_cmd

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        chk("status_rst", 32'h0, {28'h0, link.in_bits[35:32]});
        axi_rd(A_CTRL, d, r);
        chk("ctrl_rst", 32'h0, d);
        chk("irq_rst", 32'h0, {31'h0, irq});
    endtask : t_reset

    task automatic t_write_read;
        logic [31:0] rv;
        do_cmd(12'h003, 8'hB0, 32'h0000_1234, 3'b011, 1'b0, rv);
        chk("stored", 32'h0000_1234, rv);
        do_cmd(12'h003, 8'hB0, 32'h0, 3'b001, 1'b0, rv);
        chk("readback", 32'h0000_1234, rv);
        chk("coerced_early", 32'h0, {31'h0, saw_coer});
        do_cmd(12'h003, 8'hB0, 32'h0001_0000, 3'b011, 1'b0, rv);
        chk("clamped", 32'h0000_FFFF, rv);
        chk("coerced_seen", 32'h1, {31'h0, saw_coer});
    endtask : t_write_read

    task automatic t_faults;
        logic [31:0] rv;
        do_cmd(12'h003, 8'hB0, 32'h5, 3'b101, 1'b1, rv);
        do_cmd(12'h003, 8'hB1, 32'h0, 3'b001, 1'b1, rv);
        do_cmd(12'h010, 8'hB0, 32'h0, 3'b001, 1'b1, rv);
    endtask : t_faults

    task automatic t_styles;
        logic [31:0] rv;
        styles <= 9'h020;
        do_cmd(12'h003, 8'hB0, 32'h7, 3'b011, 1'b1, rv);
        styles <= STYLES_B;
        do_cmd(12'h003, 8'hB0, 32'h0, 3'b001, 1'b0, rv);
        chk("styles_read", 32'h0000_FFFF, rv);
    endtask : t_styles

    // freeze just after go: neither end may move until the enable returns
    task automatic t_freeze;
        logic [31:0] d;
        logic [1:0]  r;
        int          i;
        axi_wr(A_IRQ_ST, 32'h3, r);
        axi_wr(A_CTRL, 32'h1, r);
        ce <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("frozen_status", 32'h0, {28'h0, link.in_bits[ST_COERCED:ST_ACTIVE]});
        ce <= 1'b1;
        d = 32'h0;
        for (i = 0; i < 40 && d[IRQ_DONE] == 1'b0; i++) axi_rd(A_IRQ_ST, d, r);
        if (i == 40) timeout();
        chk("thawed_done", 32'h1, d);
        axi_rd(A_RVAL, d, r);
        chk("thawed_read", 32'h0000_FFFF, d);
    endtask : t_freeze

    task automatic t_irq_regs;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(A_IRQ_MSK, 32'h0, r);
        chk("irq_masked", 32'h0, {31'h0, irq});
        axi_wr(A_IRQ_MSK, 32'h1, r);
        chk("irq_raised", 32'h1, {31'h0, irq});
        axi_wr(A_IRQ_ST, 32'h1, r);
        axi_rd(A_IRQ_ST, d, r);
        chk("irq_status", 32'h0, d);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        axi_rd(8'h20, d, r);
        chk("bad_rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("bad_rdata", 32'h0, d);
        axi_wr(8'h20, 32'hFFFF_FFFF, r);
        chk("bad_bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask : t_irq_regs

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_write_read();
        t_faults();
        t_styles();
        t_freeze();
        t_irq_regs();
        end_sim();
    end
endmodule : tb_gateway_command_handshake
